// >>> pkg/acs_regs.vh
// constants for the converter cycle sequencer
`ifndef ACS_REGS_VH
`define ACS_REGS_VH
`define ACS_WORD_BITS      24
`define ACS_RESULT_BITS    21
`define ACS_CLK_HZ         10000000
`define ACS_POR_US         1000
`define ACS_POR_CYCLES     ((`ACS_CLK_HZ / 1000000) * `ACS_POR_US)
`define ACS_CONV_CYCLES    64
`define ACS_CAL_CYCLES     8
`define ACS_ISCK_HALF      4
`define ACS_CNT_BITS       24
`define ACS_BIT_CNT_BITS   5
`define ACS_OVER_CODE      21'h100000
`define ACS_UNDER_CODE     21'h0FFFFF
`define ACS_FIXED_LOW_BIT  1'h0
`endif

// >>> design/acs_word_buffer.v
// two-entry valid/ready buffer for finished result words
module acs_word_buffer #(
   parameter WIDTH = 23
) (
   input  wire             clock,
   input  wire             sys_rst,
   input  wire [WIDTH-1:0] inData,
   input  wire             inValid,
   output wire             inReady,
   output wire [WIDTH-1:0] outData,
   output wire             outValid,
   input  wire             outReady
);
   reg [WIDTH-1:0] mem_reg [0:1];
   reg             wrPtr_reg;
   reg             rdPtr_reg;
   reg [1:0]       count_reg;
   wire            doPush;
   wire            doPop;

   assign inReady  = (count_reg != 2'h2);
   assign outValid = (count_reg != 2'h0);
   assign outData  = mem_reg[rdPtr_reg];
   assign doPush   = inValid && inReady;
   assign doPop    = outValid && outReady;

   always @(posedge clock) begin
      if (sys_rst) begin
         wrPtr_reg <= 1'h0;
         rdPtr_reg <= 1'h0;
         count_reg <= 2'h0;
         mem_reg[0] <= {WIDTH{1'b0}};
         mem_reg[1] <= {WIDTH{1'b0}};
      end else begin
         if (doPush) begin
            mem_reg[wrPtr_reg] <= inData;
            wrPtr_reg <= ~wrPtr_reg;
         end
         if (doPop)
            rdPtr_reg <= ~rdPtr_reg;
         if (doPush && !doPop)
            count_reg <= count_reg + 2'h1;
         else if (doPop && !doPush)
            count_reg <= count_reg - 2'h1;
      end
   end
endmodule // acs_word_buffer

// >>> design/acs_cycle_sequencer.v
// conversion / sleep / data-output sequencer with serial result output
`include "acs_regs.vh"
module acs_cycle_sequencer #(
   parameter POR_CYCLES  = `ACS_POR_CYCLES,
   parameter CONV_CYCLES = `ACS_CONV_CYCLES
) (
   input  wire                        clock,
   input  wire                        sys_rst,
   input  wire                        supplyGood,
   input  wire                        chipSelectN,
   input  wire                        serialClockIn,
   output reg                         serialClockOut,
   output reg                         serialClockOe,
   output reg                         dataOut,
   output reg                         dataOutOe,
   input  wire [`ACS_RESULT_BITS-1:0] sampleResult,
   input  wire                        sampleSign,
   input  wire                        sampleOver,
   input  wire                        sampleUnder,
   output reg                         converting,
   output reg                         sleeping,
   output reg                         porActive,
   output reg                         calibrating
);
   localparam ST_CONV  = 4'h1;
   localparam ST_SLEEP = 4'h2;
   localparam ST_OUT   = 4'h4;
   localparam ST_POR   = 4'h8;
   localparam WB       = `ACS_WORD_BITS - 1;

   // two-flop synchronisers for pins
   reg        csMeta_reg;
   reg        csSync_reg;
   reg        csLast_reg;
   reg        sckMeta_reg;
   reg        sckSync_reg;
   reg        sckLast_reg;
   reg        pwrMeta_reg;
   reg        pwrSync_reg;
   reg [3:0]  state_reg;
   reg [`ACS_CNT_BITS-1:0]     cnt_reg;
   reg [`ACS_BIT_CNT_BITS-1:0] bitCnt_reg;
   reg [WB-1:0] shift_reg;
   reg        started_reg;
   reg        intMode_reg;
   reg        modeArmed_reg;
   reg [2:0]  halfCnt_reg;
   reg        iSck_reg;
   reg        pending_reg;

   wire       csFall  = csLast_reg && !csSync_reg;
   wire       csRise  = !csLast_reg && csSync_reg;
   wire       extRise = !intMode_reg && !sckLast_reg && sckSync_reg && !csSync_reg;
   wire       extFall = !intMode_reg && sckLast_reg && !sckSync_reg && !csSync_reg;
   wire       intTick = intMode_reg && (halfCnt_reg == `ACS_ISCK_HALF - 1);
   wire       intRise = intTick && !iSck_reg;
   wire       intFall = intTick && iSck_reg;
   wire       sRise   = extRise || intRise;
   wire       sFall   = extFall || intFall;

   // finished word, clamped codes for out-of-range inputs
   reg  [`ACS_RESULT_BITS:0] codeWord;
   always @* begin
      codeWord = {sampleSign, sampleResult};
      if (sampleOver)
         codeWord = {1'b1, `ACS_OVER_CODE};
      else if (sampleUnder)
         codeWord = {1'b0, `ACS_UNDER_CODE};
   end

   // result staging: conversion pushes, sleep entry pops into shifter
   wire           bufInReady;
   wire [WB-1:0]  bufOut;
   wire           bufOutValid;
   wire           convDone = (state_reg == ST_CONV) && (cnt_reg == CONV_CYCLES - 1);
   wire           bufPush  = convDone && bufInReady;
   wire           bufPop   = (state_reg == ST_SLEEP) && pending_reg && bufOutValid;

   acs_word_buffer #(
      .WIDTH (WB)
   ) u_buf (
      .clock    (clock),
      .sys_rst  (sys_rst || porActive),
      .inData   ({`ACS_FIXED_LOW_BIT, codeWord}),
      .inValid  (convDone),
      .inReady  (bufInReady),
      .outData  (bufOut),
      .outValid (bufOutValid),
      .outReady (bufPop)
   );

   // chip select idles high so reset fakes no falling edge
   // feeds the edge finder and the output enable
   always @(posedge clock) begin
      if (sys_rst) begin
         csMeta_reg <= 1'h1;
         csSync_reg <= 1'h1;
      end else begin
         csMeta_reg <= chipSelectN;
         csSync_reg <= csMeta_reg;
      end
   end

   // serial clock pin, read by the edge finder and the mode strap
   always @(posedge clock) begin
      if (sys_rst) begin
         sckMeta_reg <= 1'h0;
         sckSync_reg <= 1'h0;
      end else begin
         sckMeta_reg <= serialClockIn;
         sckSync_reg <= sckMeta_reg;
      end
   end

   // supply-good; low holds all but the pin synchronisers in reset
   // an async pin, two flops before use
   always @(posedge clock) begin
      if (sys_rst) begin
         pwrMeta_reg <= 1'h0;
         pwrSync_reg <= 1'h0;
      end else begin
         pwrMeta_reg <= supplyGood;
         pwrSync_reg <= pwrMeta_reg;
      end
   end

   // edge history for chip select and serial clock
   always @(posedge clock) begin
      if (sys_rst || !pwrSync_reg) begin
         csLast_reg  <= 1'h1;
         sckLast_reg <= 1'h0;
      end else begin
         csLast_reg  <= csSync_reg;
         sckLast_reg <= sckSync_reg;
      end
   end

   // mode strap: caught after power-up, then on each chip select fall
   // pin low at the strap moment selects the internal clock
   always @(posedge clock) begin
      if (sys_rst || !pwrSync_reg) begin
         intMode_reg   <= 1'h0;
         modeArmed_reg <= 1'h1;
      end else if (modeArmed_reg || csFall) begin
         intMode_reg   <= !sckSync_reg;
         modeArmed_reg <= 1'h0;
      end
   end

   // internal serial clock, parked low outside an active output state
   // restarts low on every entry so the first edge is a rise
   always @(posedge clock) begin
      if (sys_rst || !pwrSync_reg) begin
         halfCnt_reg <= 3'h0;
         iSck_reg    <= 1'h0;
      end else if (state_reg != ST_OUT || csSync_reg) begin
         halfCnt_reg <= 3'h0;
         iSck_reg    <= 1'h0;
      end else if (intMode_reg) begin
         if (intTick) begin
            halfCnt_reg <= 3'h0;
            iSck_reg    <= ~iSck_reg;
         end else
            halfCnt_reg <= halfCnt_reg + 3'h1;
      end
   end

   // final slice of every conversion is the gain calibration
   // level is high through the last cycles of a conversion
   always @(posedge clock) begin
      if (sys_rst || !pwrSync_reg)
         calibrating <= 1'h0;
      else
         calibrating <= (state_reg == ST_CONV) && !convDone
                        && (cnt_reg >= CONV_CYCLES - `ACS_CAL_CYCLES - 1);
   end

   // result shifter: loaded in sleep, static until a frame starts
   // bit count runs on rises; the word ends on the last fall
   always @(posedge clock) begin
      if (sys_rst || !pwrSync_reg) begin
         shift_reg   <= {WB{1'b0}};
         bitCnt_reg  <= {`ACS_BIT_CNT_BITS{1'b0}};
         started_reg <= 1'h0;
      end else if (state_reg == ST_SLEEP) begin
         if (bufPop)
            shift_reg <= bufOut;
         started_reg <= 1'h0;
         bitCnt_reg  <= {`ACS_BIT_CNT_BITS{1'b0}};
      end else if (state_reg == ST_OUT && !csSync_reg) begin
         if (sRise) begin
            started_reg <= 1'h1;
            bitCnt_reg  <= bitCnt_reg + 1'b1;
         end
         if (sFall && started_reg)
            shift_reg <= {shift_reg[WB-2:0], 1'b0};
      end
   end

   // state sequence
   // one-hot codes; an illegal code falls back to power-on
   always @(posedge clock) begin
      if (sys_rst || !pwrSync_reg) begin
         state_reg   <= ST_POR;
         cnt_reg     <= {`ACS_CNT_BITS{1'b0}};
         pending_reg <= 1'h0;
      end else begin
         case (state_reg)
            ST_POR: begin
               if (cnt_reg == POR_CYCLES - 1) begin
                  state_reg <= ST_CONV;
                  cnt_reg   <= {`ACS_CNT_BITS{1'b0}};
               end else
                  cnt_reg <= cnt_reg + 1'b1;
            end

            ST_CONV: begin
               if (convDone) begin
                  // buffer always has room: one word per conversion
                  state_reg   <= ST_SLEEP;
                  // pending flag set only for a word the buffer took
                  pending_reg <= bufPush;
                  cnt_reg     <= {`ACS_CNT_BITS{1'b0}};
               end else
                  cnt_reg <= cnt_reg + 1'b1;
            end

            ST_SLEEP: begin
               // held in sleep while chip select high; the shifter still loads on the pop
               if (bufPop)
                  pending_reg <= 1'h0;
               else if (!csSync_reg && !pending_reg)
                  state_reg <= ST_OUT;
            end

            ST_OUT: begin
               if (csSync_reg) begin
                  // abort before any rising edge keeps the word
                  state_reg <= started_reg ? ST_CONV : ST_SLEEP;
                  cnt_reg   <= {`ACS_CNT_BITS{1'b0}};
               end else if (sFall && started_reg && bitCnt_reg == `ACS_WORD_BITS) begin
                  state_reg <= ST_CONV;
                  cnt_reg   <= {`ACS_CNT_BITS{1'b0}};
               end
            end
            default: state_reg <= ST_POR;
         endcase
      end
   end

   // pin and status outputs, all straight from flops
   always @(posedge clock) begin
      if (sys_rst || !pwrSync_reg) begin
         serialClockOut <= 1'h0;
         serialClockOe  <= 1'h0;
         dataOut        <= 1'h0;
         dataOutOe      <= 1'h0;
         converting     <= 1'h0;
         sleeping       <= 1'h0;
         porActive      <= 1'h1;
      end else begin
         // status levels rise one clock after the state; porActive and converting fall with it
         porActive  <= (state_reg == ST_POR) && (cnt_reg != POR_CYCLES - 1);
         converting <= (state_reg == ST_CONV) && !convDone;
         sleeping   <= (state_reg == ST_SLEEP);
         // released while chip select high
         dataOutOe  <= !csSync_reg && (state_reg != ST_POR);
         if (state_reg == ST_OUT) begin
            // status bit stands until the first fall after the first rise
            if (!started_reg)
               dataOut <= 1'h0;
            else if (sFall)
               dataOut <= shift_reg[WB-1];
         end else
            dataOut <= (state_reg != ST_SLEEP) || pending_reg;

         serialClockOe  <= intMode_reg && (state_reg == ST_OUT) && !csSync_reg;
         serialClockOut <= iSck_reg;
      end
   end
endmodule // acs_cycle_sequencer

// >>> tb/acs_cycle_sequencer_sva.sv
// port assertions for the conversion cycle sequencer
module acs_cycle_sequencer_sva #(
   parameter POR_CYCLES  = 10000,
   parameter CONV_CYCLES = 64
) (
   input logic clock,
   input logic sys_rst,
   input logic supplyGood,
   input logic chipSelectN,
   input logic serialClockOe,
   input logic dataOut,
   input logic dataOutOe,
   input logic converting,
   input logic sleeping,
   input logic porActive,
   input logic calibrating
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] porCnt;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // restarts on any reset source so a supply dip measures a fresh pulse
   always @(posedge clock) begin
      if (sys_rst || !supplyGood) porCnt <= 16'h0;
      else if (porActive) porCnt <= porCnt + 16'h1;
   end
   AST_OE_RELEASE: assert property (chipSelectN [*4] |-> !dataOutOe)
      else $error("data pin driven while deselected");
   AST_SLEEP_HOLD: assert property ((sleeping && chipSelectN && supplyGood) [*3] |=> sleeping)
      else $error("left sleep while deselected");
   AST_SLEEP_EXIT: assert property ($fell(chipSelectN) && sleeping |-> ##[1:6] !sleeping)
      else $error("select did not end sleep");
   AST_STATE_EXCL: assert property ($onehot0({converting, sleeping, porActive}))
      else $error("two states at once");
   AST_CAL: assert property ($fell(converting) && supplyGood |-> $past(calibrating, 2))
      else $error("conversion without calibration");
   AST_CONV_TO_SLEEP: assert property ($fell(converting) && supplyGood |-> ##[0:2] sleeping)
      else $error("conversion not followed by sleep");
   AST_POR_LEN: assert property ($fell(porActive) |-> porCnt >= POR_CYCLES - 1 && porCnt <= POR_CYCLES + 6)
      else $error("power-on pulse length wrong");
   AST_POR_TO_CONV: assert property ($fell(porActive) |-> ##[0:2] converting)
      else $error("no conversion after power-on pulse");
   AST_SUPPLY_LOW: assert property (!supplyGood [*4] |-> porActive && !converting && !dataOutOe)
      else $error("running with supply low");
   AST_SCK_OE: assert property (serialClockOe |-> dataOutOe && !sleeping && !converting)
      else $error("clock pin driven outside output");
   AST_PENDING: assert property ((converting && !chipSelectN) [*5] |-> dataOut && dataOutOe)
      else $error("pending flag not shown");
   cover property ($fell(converting) ##[1:200] $fell(chipSelectN));
   cover property ($rose(chipSelectN) && dataOutOe && !sleeping);
   cover property (!supplyGood [*4]);
endmodule // acs_cycle_sequencer_sva

bind acs_cycle_sequencer acs_cycle_sequencer_sva #(.POR_CYCLES(POR_CYCLES),
   .CONV_CYCLES(CONV_CYCLES)) acs_cycle_sequencer_sva_i (.clock(clock), .sys_rst(sys_rst),
   .supplyGood(supplyGood), .chipSelectN(chipSelectN), .serialClockOe(serialClockOe),
   .dataOut(dataOut), .dataOutOe(dataOutOe), .converting(converting), .sleeping(sleeping),
   .porActive(porActive), .calibrating(calibrating));

// >>> tb/acs_host_model.sv
// host model: chip select, external serial clock, data sampling
module acs_host_model (
   input  logic clock,
   output logic chipSelectN,
   output logic serialClock,
   input  logic dataOut,
   input  logic dataOutOe,
   input  logic sckPin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      chipSelectN = 1'h1;
      serialClock = 1'h1; // idle high keeps external clock mode
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clock);
   endtask
   // word starts with the bit shown before the first rise
   task automatic frame(input int nBits, output logic [23:0] word);
      chipSelectN <= 1'h0;
      wait_clk(8);
      word = {23'h0, dataOutOe ? dataOut : 1'hx};
      for (int i = 0; i < nBits; i++) begin
         serialClock <= 1'h0;
         wait_clk(4);
         word = {word[22:0], dataOutOe ? dataOut : 1'hx};
         serialClock <= 1'h1;
         wait_clk(4);
      end
      if (nBits == 24) begin
         serialClock <= 1'h0;
         wait_clk(4);
      end
      chipSelectN <= 1'h1;
      serialClock <= 1'h1;
      wait_clk(4);
   endtask
   // internal clock mode: pin low at select, device clocks the word out
   task automatic int_frame(output logic [23:0] word);
      int n;
      int i;
      logic last;
      n = 0;
      i = 0;
      word = 24'h0;
      serialClock <= 1'h0;
      wait_clk(2);
      chipSelectN <= 1'h0;
      last = sckPin;
      while (i < 24 && n < 400) begin
         wait_clk(1);
         n++;
         if (sckPin === 1'h1 && last === 1'h0) begin
            word = {word[22:0], dataOutOe ? dataOut : 1'hx};
            i++;
         end
         last = sckPin;
      end
      wait_clk(8);
      chipSelectN <= 1'h1;
      serialClock <= 1'h1;
      wait_clk(4);
   endtask
   // clock pulses while deselected, which must be ignored
   task automatic noise();
      repeat (6) begin
         serialClock <= ~serialClock;
         wait_clk(4);
      end
   endtask
endmodule // acs_host_model

// >>> tb/acs_cycle_sequencer_tb.sv
// testbench for the conversion cycle sequencer
`include "acs_regs.vh"
module acs_cycle_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int POR = 20;
   logic clock = 1'h0;
   logic sys_rst = 1'h1;
   logic supplyGood = 1'h1;
   logic sampleOver = 1'h0, sampleUnder = 1'h0, sampleSign = 1'h0;
   logic [`ACS_RESULT_BITS-1:0] sampleResult = 21'h0;
   logic chipSelectN, hostSck, serialClockOut, serialClockOe, dataOut, dataOutOe;
   logic converting, sleeping, porActive, calibrating;
   logic [23:0] word;
   logic [23:0] stim [3] = '{24'h212345, 24'h800000, 24'h400000};
   logic [23:0] expWord [3] = '{24'h212345, 24'h300000, 24'h0FFFFF};
   int failures = 0;
   int checked = 0;
   wire sckPin = serialClockOe ? serialClockOut : hostSck;
   always #50 clock = ~clock;
   acs_cycle_sequencer #(.POR_CYCLES(POR), .CONV_CYCLES(`ACS_CONV_CYCLES)) acs_cycle_sequencer_i (
      .clock(clock), .sys_rst(sys_rst), .supplyGood(supplyGood), .chipSelectN(chipSelectN),
      .serialClockIn(sckPin), .serialClockOut(serialClockOut), .serialClockOe(serialClockOe),
      .dataOut(dataOut), .dataOutOe(dataOutOe), .sampleResult(sampleResult),
      .sampleSign(sampleSign), .sampleOver(sampleOver), .sampleUnder(sampleUnder),
      .converting(converting), .sleeping(sleeping), .porActive(porActive),
      .calibrating(calibrating));
   acs_host_model acs_host_model_i (.clock(clock), .chipSelectN(chipSelectN),
      .serialClock(hostSck), .dataOut(dataOut), .dataOutOe(dataOutOe), .sckPin(sckPin));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   // bounded wait for sleep (1) or conversion (0)
   task automatic wait_state(input logic wantSleep);
      int n;
      n = 0;
      while ((wantSleep ? sleeping : converting) !== 1'h1 && n < 400) begin
         @(negedge clock);
         n++;
      end
      if (n == 400) begin
         failures++;
         finish_test();
      end
   endtask
   initial begin
      repeat (2) @(negedge clock);
      sys_rst = 1'h0;
      repeat (POR - 4) @(negedge clock);
      check("power-on", 24'h1, {23'h0, porActive});
      wait_state(1'h0);
      wait_state(1'h1);
      acs_host_model_i.frame(24, word);
      check("first word", 24'h0, word);
      for (int k = 0; k < 3; k++) begin
         {sampleOver, sampleUnder, sampleSign, sampleResult} = stim[k];
         wait_state(1'h1);
         acs_host_model_i.frame(24, word);
         check("word", expWord[k], word);
         check("restart", 24'h1, {23'h0, converting});
      end
      {sampleOver, sampleUnder, sampleSign, sampleResult} = 24'h3F0000;
      wait_state(1'h1);
      acs_host_model_i.noise();
      acs_host_model_i.frame(0, word);
      check("eoc low", 24'h0, word);
      wait_state(1'h1);
      check("no restart", 24'h0, {23'h0, converting});
      sampleResult = 21'h0;
      acs_host_model_i.frame(5, word);
      check("kept word", 24'h7, word);
      check("abort", 24'h1, {23'h0, converting});
      {sampleOver, sampleUnder, sampleSign, sampleResult} = 24'h000055;
      acs_host_model_i.frame(0, word);
      check("pending", 24'h1, word);
      wait_state(1'h1);
      acs_host_model_i.frame(24, word);
      check("fresh word", 24'h000055, word);
      {sampleOver, sampleUnder, sampleSign, sampleResult} = 24'h1ABCDE;
      wait_state(1'h1);
      acs_host_model_i.int_frame(word);
      check("internal clock word", 24'h1ABCDE, word);
      supplyGood = 1'h0;
      repeat (6) @(negedge clock);
      check("supply low", 24'h1, {23'h0, porActive});
      supplyGood = 1'h1;
      wait_state(1'h0);
      finish_test();
   end
endmodule // acs_cycle_sequencer_tb
